/* core/brw_regs.sv */
/*
 * Secondary status and address window register slice of a
 * PCIe-to-PCI bridge, with registered window decode.
 * Assumes a single-cycle register port from configuration logic and
 * secondary-bus event strobes from logic on sys_clk_i; two bus pins
 * arrive asynchronously and are synchronised here.
 */
`timescale 1ns/1ps
`default_nettype none

// Behaviour
// - status bit 21 always reads 1 (66 MHz capable), writes ignored
// - status bit 23 always reads 1 (fast back-to-back), writes ignored
// - bit 24 sets on enabled read, write or split-completion data parity errors
// - bits 26:25 read fixed 01, medium target decode
// - bit 27 sets when bridge signals target abort as target
// - bit 28 sets when bridge's own transaction receives target abort
// - bit 29 sets when bridge's transaction ends in master abort
// - bit 30 sets when system error seen asserted on secondary bus
// - bit 31 sets only on bus_parity_err_i, not on the parity errors that set bit 24
// - memory base bits 15:4 RW, address 31:20, low bits zero
// - memory limit bits 31:20 RW, address 31:20, low bits ones
// - prefetchable base and limit low nibbles read 0001
// - prefetchable base bits 15:4 RW, window start 31:20
// - prefetchable limit bits 31:20 RW, window end 31:20
// - 32-bit RW register holds prefetchable start bits 63:32
// - 32-bit RW register holds prefetchable end bits 63:32
// - low half word holds I/O window start bits 31:16
// - upper half word holds I/O window end bits 31:16
module brw_regs
    import brw_pkg::*;
(
    input  wire logic        sys_clk_i,
    input  wire logic        rst_n_i,
    // register port
    input  wire logic [7:0]  reg_addr_i,
    input  wire logic [31:0] reg_wdata_i,
    input  wire logic        reg_wr_i,
    input  wire logic        reg_rd_i,
    output logic      [31:0] reg_rdata_o,
    // secondary bus pins, asynchronous, active low
    input  wire logic        secondary_parity_err_n_i,
    input  wire logic        secondary_sys_err_n_i,
    // secondary bus events from bridge logic, one-cycle pulses
    input  wire logic        write_data_phase_i,
    input  wire logic        read_data_perr_i,
    input  wire logic        split_wr_perr_msg_i,
    input  wire logic        signaled_tabort_i,
    input  wire logic        received_tabort_i,
    input  wire logic        received_mabort_i,
    input  wire logic        bus_parity_err_i,
    // window decode
    input  wire logic [63:0] lookup_addr_i,
    output logic             mem_hit_o,
    output logic             pf_hit_o,
    output logic             io_hit_o,
    output logic             perr_resp_en_o
);

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    typedef struct packed {
        logic        mst_dperr;
        logic        sig_tabort;
        logic        rcv_tabort;
        logic        rcv_mabort;
        logic        rcv_serr;
        logic        det_perr;
        logic [11:0] mem_base;
        logic [11:0] mem_limit;
        logic [11:0] pf_base;
        logic [11:0] pf_limit;
        logic [31:0] pf_base_hi;
        logic [31:0] pf_limit_hi;
        logic [15:0] io_base_hi;
        logic [15:0] io_limit_hi;
        logic        perr_resp_en;
        logic [31:0] rdata;
        logic        mem_hit;
        logic        pf_hit;
        logic        io_hit;
    } brw_state_type;

    brw_state_type state_ff;
    brw_state_type nxt_state;

    logic        perr_pin_n;
    logic        serr_pin_n;
    logic        mem_hit;
    logic        pf_hit;
    logic        io_hit;
    logic [31:0] status_word;
    logic [31:0] mem_word;
    logic [31:0] pf_word;
    logic [31:0] mem_base_addr;
    logic [31:0] mem_limit_addr;
    logic [63:0] pf_base_addr;
    logic [63:0] pf_limit_addr;
    logic [31:0] io_base_addr;
    logic [31:0] io_limit_addr;
    logic        wr_status;
    logic [31:0] w1c;

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    brw_pin_sync #(
        .WIDTH (2)
    ) u_pin_sync (
        .sys_clk_i (sys_clk_i),
        .rst_n_i   (rst_n_i),
        .pin_i     ({secondary_sys_err_n_i, secondary_parity_err_n_i}),
        .rst_val_i (2'h3),
        .level_o   ({serr_pin_n, perr_pin_n})
    );

    // ------------------------------------------------------------
    // window assembly and decode
    // ------------------------------------------------------------
    assign mem_base_addr  = {state_ff.mem_base, BRW_LOW_ZEROS};
    assign mem_limit_addr = {state_ff.mem_limit, BRW_LOW_ONES};
    assign pf_base_addr   = {state_ff.pf_base_hi, state_ff.pf_base, BRW_LOW_ZEROS};
    assign pf_limit_addr  = {state_ff.pf_limit_hi, state_ff.pf_limit, BRW_LOW_ONES};
    // low I/O bits live outside this slice; the window spans whole 64 KB pages here
    assign io_base_addr   = {state_ff.io_base_hi, BRW_IO_ZEROS};
    assign io_limit_addr  = {state_ff.io_limit_hi, BRW_IO_ONES};

    brw_window_cmp #(
        .WIDTH (32)
    ) u_mem_cmp (
        .addr_i  (lookup_addr_i[31:0]),
        .base_i  (mem_base_addr),
        .limit_i (mem_limit_addr),
        .hit_o   (mem_hit)
    );

    brw_window_cmp #(
        .WIDTH (64)
    ) u_pf_cmp (
        .addr_i  (lookup_addr_i),
        .base_i  (pf_base_addr),
        .limit_i (pf_limit_addr),
        .hit_o   (pf_hit)
    );

    brw_window_cmp #(
        .WIDTH (32)
    ) u_io_cmp (
        .addr_i  (lookup_addr_i[31:0]),
        .base_i  (io_base_addr),
        .limit_i (io_limit_addr),
        .hit_o   (io_hit)
    );

    // ------------------------------------------------------------
    // read views
    // ------------------------------------------------------------
    always_comb
    begin
        status_word = 32'h0000_0000;
        status_word[BRW_BIT_66MHZ]    = 1'b1;
        status_word[BRW_BIT_FAST_B2B] = 1'b1;
        status_word[BRW_LSB_DEVSEL +: 2] = BRW_DEVSEL_MEDIUM;
        status_word[BRW_BIT_MST_DPERR]  = state_ff.mst_dperr;
        status_word[BRW_BIT_SIG_TABORT] = state_ff.sig_tabort;
        status_word[BRW_BIT_RCV_TABORT] = state_ff.rcv_tabort;
        status_word[BRW_BIT_RCV_MABORT] = state_ff.rcv_mabort;
        status_word[BRW_BIT_RCV_SERR]   = state_ff.rcv_serr;
        status_word[BRW_BIT_DET_PERR]   = state_ff.det_perr;
    end

    always_comb
    begin
        mem_word = 32'h0000_0000;
        mem_word[BRW_LSB_BASE_FIELD +: 12]  = state_ff.mem_base;
        mem_word[BRW_LSB_LIMIT_FIELD +: 12] = state_ff.mem_limit;
    end

    always_comb
    begin
        pf_word = 32'h0000_0000;
        pf_word[3:0] = BRW_PF_64BIT_CODE;
        pf_word[BRW_LSB_PF_CODE_LIM +: 4]  = BRW_PF_64BIT_CODE;
        pf_word[BRW_LSB_BASE_FIELD +: 12]  = state_ff.pf_base;
        pf_word[BRW_LSB_LIMIT_FIELD +: 12] = state_ff.pf_limit;
    end

    // ------------------------------------------------------------
    // next state
    // ------------------------------------------------------------
    assign wr_status = reg_wr_i && (reg_addr_i == BRW_OFF_SEC_STATUS);
    assign w1c       = wr_status ? reg_wdata_i : 32'h0000_0000;

    always_comb
    begin
        nxt_state = state_ff;

        // sticky flags: a new event beats a same-cycle clear
        nxt_state.mst_dperr = (state_ff.mst_dperr & ~w1c[BRW_BIT_MST_DPERR])
                            | (state_ff.perr_resp_en
                               & (read_data_perr_i
                                  | (write_data_phase_i & ~perr_pin_n)
                                  | split_wr_perr_msg_i));
        nxt_state.sig_tabort = (state_ff.sig_tabort & ~w1c[BRW_BIT_SIG_TABORT])
                             | signaled_tabort_i;
        nxt_state.rcv_tabort = (state_ff.rcv_tabort & ~w1c[BRW_BIT_RCV_TABORT])
                             | received_tabort_i;
        nxt_state.rcv_mabort = (state_ff.rcv_mabort & ~w1c[BRW_BIT_RCV_MABORT])
                             | received_mabort_i;
        nxt_state.rcv_serr   = (state_ff.rcv_serr & ~w1c[BRW_BIT_RCV_SERR])
                             | ~serr_pin_n;
        // no enable gate here, unlike bit 24
        nxt_state.det_perr   = (state_ff.det_perr & ~w1c[BRW_BIT_DET_PERR])
                             | bus_parity_err_i;

        if (reg_wr_i)
        begin
            case (reg_addr_i)
                BRW_OFF_MEM_WIN:
                begin
                    nxt_state.mem_base  = reg_wdata_i[BRW_LSB_BASE_FIELD +: 12];
                    nxt_state.mem_limit = reg_wdata_i[BRW_LSB_LIMIT_FIELD +: 12];
                end
                BRW_OFF_PF_WIN:
                begin
                    nxt_state.pf_base  = reg_wdata_i[BRW_LSB_BASE_FIELD +: 12];
                    nxt_state.pf_limit = reg_wdata_i[BRW_LSB_LIMIT_FIELD +: 12];
                end
                BRW_OFF_PF_BASE_HI:  nxt_state.pf_base_hi  = reg_wdata_i;
                BRW_OFF_PF_LIMIT_HI: nxt_state.pf_limit_hi = reg_wdata_i;
                BRW_OFF_IO_HI:
                begin
                    nxt_state.io_base_hi  = reg_wdata_i[15:0];
                    nxt_state.io_limit_hi = reg_wdata_i[BRW_LSB_IO_LIMIT +: 16];
                end
                BRW_OFF_ERR_CTRL:
                    nxt_state.perr_resp_en = reg_wdata_i[BRW_BIT_PERR_RESP_EN];
                default: ;
            endcase
        end

        // read data stand for exactly one cycle after the strobe
        nxt_state.rdata = 32'h0000_0000;
        if (reg_rd_i)
        begin
            case (reg_addr_i)
                BRW_OFF_SEC_STATUS:  nxt_state.rdata = status_word;
                BRW_OFF_MEM_WIN:     nxt_state.rdata = mem_word;
                BRW_OFF_PF_WIN:      nxt_state.rdata = pf_word;
                BRW_OFF_PF_BASE_HI:  nxt_state.rdata = state_ff.pf_base_hi;
                BRW_OFF_PF_LIMIT_HI: nxt_state.rdata = state_ff.pf_limit_hi;
                BRW_OFF_IO_HI:
                    nxt_state.rdata = {state_ff.io_limit_hi, state_ff.io_base_hi};
                BRW_OFF_ERR_CTRL:
                    nxt_state.rdata[BRW_BIT_PERR_RESP_EN] = state_ff.perr_resp_en;
                default:             nxt_state.rdata = 32'h0000_0000;
            endcase
        end

        nxt_state.mem_hit = mem_hit;
        nxt_state.pf_hit  = pf_hit;
        nxt_state.io_hit  = io_hit;
    end

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_ff              <= '0;
            state_ff.mem_base     <= BRW_RST_WIN12;
            state_ff.mem_limit    <= BRW_RST_WIN12;
            state_ff.pf_base      <= BRW_RST_WIN12;
            state_ff.pf_limit     <= BRW_RST_WIN12;
            state_ff.pf_base_hi   <= BRW_RST_WORD;
            state_ff.pf_limit_hi  <= BRW_RST_WORD;
            state_ff.io_base_hi   <= BRW_RST_HALF;
            state_ff.io_limit_hi  <= BRW_RST_HALF;
        end
        else
            state_ff <= nxt_state;
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign reg_rdata_o    = state_ff.rdata;
    assign mem_hit_o      = state_ff.mem_hit;
    assign pf_hit_o       = state_ff.pf_hit;
    assign io_hit_o       = state_ff.io_hit;
    assign perr_resp_en_o = state_ff.perr_resp_en;

endmodule : brw_regs

`default_nettype wire

/* core/brw_pkg.sv */
/*
 * Constants for the bridge window and secondary status register slice:
 * register offsets, field positions and reset values.
 * Assumes byte offsets on an 8-bit register address, one 32-bit word each.
 */
package brw_pkg;

    // ------------------------------------------------------------
    // register offsets
    // ------------------------------------------------------------
    localparam logic [7:0] BRW_OFF_SEC_STATUS  = 8'h1c;
    localparam logic [7:0] BRW_OFF_MEM_WIN     = 8'h20;
    localparam logic [7:0] BRW_OFF_PF_WIN      = 8'h24;
    localparam logic [7:0] BRW_OFF_PF_BASE_HI  = 8'h28;
    localparam logic [7:0] BRW_OFF_PF_LIMIT_HI = 8'h2c;
    localparam logic [7:0] BRW_OFF_IO_HI       = 8'h30;
    localparam logic [7:0] BRW_OFF_ERR_CTRL    = 8'h3c;

    // ------------------------------------------------------------
    // secondary status field positions
    // ------------------------------------------------------------
    localparam int BRW_BIT_66MHZ        = 21;
    localparam int BRW_BIT_FAST_B2B     = 23;
    localparam int BRW_BIT_MST_DPERR    = 24;
    localparam int BRW_LSB_DEVSEL       = 25;
    localparam int BRW_BIT_SIG_TABORT   = 27;
    localparam int BRW_BIT_RCV_TABORT   = 28;
    localparam int BRW_BIT_RCV_MABORT   = 29;
    localparam int BRW_BIT_RCV_SERR     = 30;
    localparam int BRW_BIT_DET_PERR     = 31;
    localparam int BRW_BIT_PERR_RESP_EN = 16;

    localparam logic [1:0] BRW_DEVSEL_MEDIUM  = 2'h1;
    localparam logic [3:0] BRW_PF_64BIT_CODE  = 4'h1;

    // ------------------------------------------------------------
    // window field layout and reset values
    // ------------------------------------------------------------
    localparam int BRW_LSB_BASE_FIELD  = 4;
    localparam int BRW_LSB_LIMIT_FIELD = 20;
    localparam int BRW_LSB_PF_CODE_LIM = 16;
    localparam int BRW_LSB_IO_LIMIT    = 16;

    localparam logic [11:0] BRW_RST_WIN12  = 12'h000;
    localparam logic [31:0] BRW_RST_WORD   = 32'h0000_0000;
    localparam logic [15:0] BRW_RST_HALF   = 16'h0000;
    localparam logic [19:0] BRW_LOW_ZEROS  = 20'h0_0000;
    localparam logic [19:0] BRW_LOW_ONES   = 20'hf_ffff;
    localparam logic [15:0] BRW_IO_ZEROS   = 16'h0000;
    localparam logic [15:0] BRW_IO_ONES    = 16'hffff;

endpackage : brw_pkg

/* core/brw_pin_sync.sv */
/*
 * Three-flop synchroniser for a group of asynchronous pin levels.
 * Assumes the pins are quasi-static compared with sys_clk_i.
 */
`timescale 1ns/1ps
`default_nettype none

module brw_pin_sync
    import brw_pkg::*;
#(
    parameter int WIDTH = 2
)
(
    input  wire logic             sys_clk_i,
    input  wire logic             rst_n_i,
    input  wire logic [WIDTH-1:0] pin_i,
    input  wire logic [WIDTH-1:0] rst_val_i,
    output logic      [WIDTH-1:0] level_o
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
        logic [WIDTH-1:0] level;
    } brw_sync_type;

    brw_sync_type state_ff;
    brw_sync_type nxt_state;

    // ------------------------------------------------------------
    // per-bit agreement filter
    // ------------------------------------------------------------
    // s1 feeds s2 only; level follows once s2 and s3 agree
    always_comb
    begin
        nxt_state    = state_ff;
        nxt_state.s1 = pin_i;
        nxt_state.s2 = state_ff.s1;
        nxt_state.s3 = state_ff.s2;
        for (int i = 0; i < WIDTH; i++)
        begin
            if (state_ff.s2[i] == state_ff.s3[i])
                nxt_state.level[i] = state_ff.s3[i];
        end
    end

    // reset value is a constant tie at the instance, not a live signal
    always_ff @(posedge sys_clk_i)
    begin
        if (!rst_n_i)
        begin
            state_ff.s1    <= rst_val_i;
            state_ff.s2    <= rst_val_i;
            state_ff.s3    <= rst_val_i;
            state_ff.level <= rst_val_i;
        end
        else
            state_ff <= nxt_state;
    end

    assign level_o = state_ff.level;

endmodule : brw_pin_sync

`default_nettype wire

/* core/brw_window_cmp.sv */
/*
 * Inclusive window compare: base <= addr <= limit.
 * Assumes base and limit are already assembled to full width.
 */
`timescale 1ns/1ps
`default_nettype none

module brw_window_cmp
    import brw_pkg::*;
#(
    parameter int WIDTH = 32
)
(
    input  wire logic [WIDTH-1:0] addr_i,
    input  wire logic [WIDTH-1:0] base_i,
    input  wire logic [WIDTH-1:0] limit_i,
    output logic                  hit_o
);

    // an inverted window (base above limit) never hits
    assign hit_o = (addr_i >= base_i) && (addr_i <= limit_i);

endmodule : brw_window_cmp

`default_nettype wire

/* tb/brw_regs_properties.sv */
/*
 * Concurrent checks on the register port and status flags of brw_regs.
 * Assumes one clock domain and a synchronous active-low reset.
 */
`timescale 1ns/1ps
`default_nettype none

module brw_regs_properties
    import brw_pkg::*;
(
    input wire logic        sys_clk_i,
    input wire logic        rst_n_i,
    input wire logic [7:0]  reg_addr_i,
    input wire logic        reg_rd_i,
    input wire logic [31:0] reg_rdata_o,
    input wire logic        signaled_tabort_i,
    input wire logic        received_tabort_i,
    input wire logic        received_mabort_i,
    input wire logic        bus_parity_err_i
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (!rst_n_i);

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_rdata_idle_zero: assert property (
        !$past(reg_rd_i) |-> reg_rdata_o == 32'h0) else $error("read data not zero when idle");
    a_status_fixed: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) == BRW_OFF_SEC_STATUS |->
        reg_rdata_o[23:21] == 3'h5 && reg_rdata_o[26:25] == 2'h1)
        else $error("status fixed bits wrong");
    a_pf_code_bits: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) == BRW_OFF_PF_WIN |->
        reg_rdata_o[3:0] == 4'h1 && reg_rdata_o[19:16] == 4'h1)
        else $error("prefetch code nibbles wrong");
    a_mem_rsvd_zero: assert property (
        $past(reg_rd_i) && $past(reg_addr_i) == BRW_OFF_MEM_WIN |->
        reg_rdata_o[3:0] == 4'h0 && reg_rdata_o[19:16] == 4'h0)
        else $error("memory window reserved bits not zero");
    a_sig_tabort_flag: assert property (
        signaled_tabort_i ##1 (reg_rd_i && reg_addr_i == BRW_OFF_SEC_STATUS)
        |=> reg_rdata_o[27]) else $error("signaled target abort flag not set");
    a_rcv_tabort_flag: assert property (
        received_tabort_i ##1 (reg_rd_i && reg_addr_i == BRW_OFF_SEC_STATUS)
        |=> reg_rdata_o[28]) else $error("received target abort flag not set");
    a_mabort_flag: assert property (
        received_mabort_i ##1 (reg_rd_i && reg_addr_i == BRW_OFF_SEC_STATUS)
        |=> reg_rdata_o[29]) else $error("master abort flag not set");
    a_det_perr_flag: assert property (
        bus_parity_err_i ##1 (reg_rd_i && reg_addr_i == BRW_OFF_SEC_STATUS)
        |=> reg_rdata_o[31]) else $error("detected parity flag not set");
    a_flags_sticky: assert property (
        (reg_rd_i && reg_addr_i == BRW_OFF_SEC_STATUS) ##1
        (reg_rd_i && reg_addr_i == BRW_OFF_SEC_STATUS)
        |=> ($past(reg_rdata_o) & ~reg_rdata_o & 32'hf900_0000) == 32'h0)
        else $error("status flag dropped without a write");
endmodule : brw_regs_properties

bind brw_regs brw_regs_properties i_props (
    .sys_clk_i(sys_clk_i), .rst_n_i(rst_n_i), .reg_addr_i(reg_addr_i),
    .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o), .signaled_tabort_i(signaled_tabort_i),
    .received_tabort_i(received_tabort_i), .received_mabort_i(received_mabort_i),
    .bus_parity_err_i(bus_parity_err_i));

`default_nettype wire

/* tb/brw_sec_bus_model.sv */
/*
 * Secondary bus agents: raise bus events and error pins on request.
 * Assumes requests come from the bench one clock ahead; pins are pulled up.
 */
`timescale 1ns/1ps
`default_nettype none

module brw_sec_bus_model (
    input  wire logic       sys_clk_i,
    input  wire logic [8:0] evt_i,
    output logic            secondary_parity_err_n_o,
    output logic            secondary_sys_err_n_o,
    output logic            write_data_phase_o,
    output logic            read_data_perr_o,
    output logic            split_wr_perr_msg_o,
    output logic            signaled_tabort_o,
    output logic            received_tabort_o,
    output logic            received_mabort_o,
    output logic            bus_parity_err_o
);
    // ------------------------------------------------------------
    // event drive
    // ------------------------------------------------------------
    // released pins return to the pull-up level, never hold a stale low
    always_ff @(posedge sys_clk_i)
    begin
        signaled_tabort_o        <= evt_i[0];
        received_tabort_o        <= evt_i[1];
        received_mabort_o        <= evt_i[2];
        bus_parity_err_o         <= evt_i[3];
        read_data_perr_o         <= evt_i[4];
        split_wr_perr_msg_o      <= evt_i[5];
        secondary_sys_err_n_o    <= ~evt_i[6];
        secondary_parity_err_n_o <= ~evt_i[7];
        write_data_phase_o       <= evt_i[8];
    end
endmodule : brw_sec_bus_model

`default_nettype wire

/* tb/brw_regs_test.sv */
/*
 * Self-checking bench for brw_regs: register access, sticky flags, decode.
 * Assumes the checker is bound in and the bus model drives the event inputs.
 */
`timescale 1ns/1ps
`default_nettype none

module brw_regs_test
    import brw_pkg::*;
;
    logic        clk, rst_n, reg_wr, reg_rd, perr_n, serr_n, wphase, rdperr, splperr;
    logic        sigta, rcvta, rcvma, busperr, mem_hit, pf_hit, io_hit, perr_en;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [63:0] lookup;
    logic [8:0]  evt;
    int          n_fail, samples_checked;

    brw_regs i_dut (
        .sys_clk_i(clk), .rst_n_i(rst_n), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata),
        .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
        .secondary_parity_err_n_i(perr_n), .secondary_sys_err_n_i(serr_n),
        .write_data_phase_i(wphase), .read_data_perr_i(rdperr),
        .split_wr_perr_msg_i(splperr), .signaled_tabort_i(sigta),
        .received_tabort_i(rcvta), .received_mabort_i(rcvma), .bus_parity_err_i(busperr),
        .lookup_addr_i(lookup), .mem_hit_o(mem_hit), .pf_hit_o(pf_hit), .io_hit_o(io_hit),
        .perr_resp_en_o(perr_en));

    brw_sec_bus_model i_bus (
        .sys_clk_i(clk), .evt_i(evt), .secondary_parity_err_n_o(perr_n),
        .secondary_sys_err_n_o(serr_n), .write_data_phase_o(wphase),
        .read_data_perr_o(rdperr), .split_wr_perr_msg_o(splperr),
        .signaled_tabort_o(sigta), .received_tabort_o(rcvta),
        .received_mabort_o(rcvma), .bus_parity_err_o(busperr));

    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic tally_and_finish;
        $display("compares %0d, mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("MISMATCH at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask : chk

    task automatic reg_write(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk);
        reg_wr    <= 1'b0;
    endtask : reg_write

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd_chk

    // two status reads with no gap, so a flag must survive a read
    task automatic rd_pair(input logic [31:0] exp);
        @(posedge clk);
        reg_rd   <= 1'b1;
        reg_addr <= BRW_OFF_SEC_STATUS;
        @(posedge clk);
        #1 chk(reg_rdata, exp);
        @(posedge clk);
        reg_rd   <= 1'b0;
        #1 chk(reg_rdata, exp);
    endtask : rd_pair

    // pins are held long enough to cross the synchroniser
    task automatic bus_event(input int i);
        @(posedge clk);
        evt <= (i == 7) ? 9'h180 : 9'(1 << i);
        repeat ((i >= 6) ? 8 : 1) @(posedge clk);
        evt <= 9'h0;
        // pulse flags are read straight after, so the flag checks see event then read
        repeat ((i >= 6) ? 6 : 0) @(posedge clk);
    endtask : bus_event

    function automatic logic [31:0] status_exp(input logic [31:0] flags);
        return flags | 32'h02a0_0000;
    endfunction : status_exp

    function automatic logic hit_exp(input logic [63:0] a, input logic [63:0] b,
                                     input logic [63:0] l);
        return (a >= b) && (a <= l);
    endfunction : hit_exp

    // ------------------------------------------------------------
    // stimulus
    // ------------------------------------------------------------
    initial
    begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    initial
    begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end

    initial
    begin
        logic [7:0]  offs [8];
        logic [31:0] rsts [8];
        logic [31:0] msks [8];
        int          fbit [8];
        logic [7:0]  gated;
        logic [31:0] d, e, ph, plh;
        logic [11:0] mb, ml, pb, pl;
        logic [15:0] ib, il;
        logic [63:0] a;
        offs  = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h3c, 8'h40};
        rsts  = '{32'h02a0_0000, 32'h0, 32'h0001_0001, 32'h0, 32'h0, 32'h0, 32'h0, 32'h0};
        msks  = '{32'h0, 32'hfff0_fff0, 32'hfff0_fff0, 32'hffff_ffff, 32'hffff_ffff,
                  32'hffff_ffff, 32'h0001_0000, 32'h0};
        fbit  = '{27, 28, 29, 31, 24, 24, 30, 24};
        gated = 8'hb0;
        {reg_wr, reg_rd, reg_addr, reg_wdata, lookup, evt} = '0;
        n_fail = 0;
        samples_checked = 0;
        rst_n = 1'b0;
        void'($urandom(75415));
        repeat (8) @(posedge clk);
        rst_n <= 1'b1;
        for (int i = 0; i < 8; i++)
            rd_chk(offs[i], rsts[i]);
        for (int k = 0; k < 4; k++)
            for (int i = 0; i < 8; i++)
            begin
                d = (k == 0) ? 32'hffff_ffff : $urandom;
                reg_write(offs[i], d);
                rd_chk(offs[i], (d & msks[i]) | rsts[i]);
            end
        reg_write(BRW_OFF_SEC_STATUS, 32'hffff_ffff);
        for (int en = 0; en < 2; en++)
        begin
            reg_write(BRW_OFF_ERR_CTRL, 32'(en) << 16);
            @(posedge clk);
            #1 chk({31'h0, perr_en}, 32'(en));
            for (int i = 0; i < 8; i++)
            begin
                bus_event(i);
                e = (gated[i] && en == 0) ? 32'h0 : 32'h1 << fbit[i];
                rd_chk(BRW_OFF_SEC_STATUS, status_exp(e));
                reg_write(BRW_OFF_SEC_STATUS, 32'h0);
                rd_pair(status_exp(e));
                reg_write(BRW_OFF_SEC_STATUS, e);
                rd_chk(BRW_OFF_SEC_STATUS, status_exp(32'h0));
            end
        end
        for (int n = 0; n < 48; n++)
        begin
            mb  = 12'($urandom);
            ml  = mb + 12'($urandom_range(0, 3));
            pb  = 12'($urandom);
            pl  = pb + 12'($urandom_range(0, 3));
            ib  = 16'($urandom);
            il  = ib + 16'($urandom_range(0, 3));
            ph  = 32'($urandom_range(0, 1));
            plh = ph + 32'($urandom_range(0, 1));
            reg_write(BRW_OFF_MEM_WIN, {ml, 4'h0, mb, 4'h0});
            reg_write(BRW_OFF_PF_WIN, {pl, 4'h0, pb, 4'h0});
            reg_write(BRW_OFF_PF_BASE_HI, ph);
            reg_write(BRW_OFF_PF_LIMIT_HI, plh);
            reg_write(BRW_OFF_IO_HI, {il, ib});
            case (n % 6)
                0: a = {ph, mb, 20'h0};
                1: a = {ph, ml, 20'hf_ffff} + 64'h1;
                2: a = {ph, pb, 20'h0} - 64'h1;
                3: a = {plh, pl, 20'hf_ffff};
                4: a = {plh, il, 16'hffff} + 64'h1;
                default: a = {ph, ib, 16'h0};
            endcase
            @(posedge clk);
            lookup <= a;
            @(posedge clk);
            #1 chk({29'h0, mem_hit, pf_hit, io_hit}, {29'h0,
                hit_exp({32'h0, a[31:0]}, {32'h0, mb, 20'h0}, {32'h0, ml, 20'hf_ffff}),
                hit_exp(a, {ph, pb, 20'h0}, {plh, pl, 20'hf_ffff}),
                hit_exp({32'h0, a[31:0]}, {32'h0, ib, 16'h0}, {32'h0, il, 16'hffff})});
        end
        tally_and_finish();
    end
endmodule : brw_regs_test

`default_nettype wire
